// [core/ascu_params.svh]
// constants of the async serial character unit: offsets, field positions,
// reset values and bit-timing counts; included by the unit's design files
`ifndef ASCU_PARAMS_SVH
`define ASCU_PARAMS_SVH

// register byte offsets (one aligned 32-bit word each)
`define ASCU_OFF_DATA 8'h00
`define ASCU_OFF_STATUS 8'h04
`define ASCU_OFF_CTRL1 8'h08
`define ASCU_OFF_CTRL2 8'h0c

// status fields
`define ASCU_ST_TX_BUFFER_EMPTY_FLAG 7
`define ASCU_ST_TC 6
`define ASCU_ST_RXF 5
`define ASCU_ST_OVR 3

// control one fields
`define ASCU_C1_RX9 7
`define ASCU_C1_TX9 6
`define ASCU_C1_WLS 4

// control two fields
`define ASCU_C2_TIE 7
`define ASCU_C2_TX_DONE_IRQ_EN 6
`define ASCU_C2_TE 3
`define ASCU_C2_RE 2
`define ASCU_C2_SBK 0

// reset values
`define ASCU_CTRL1_RST 8'h00
`define ASCU_CTRL2_RST 8'h00

// frame lengths in bit times, and receive oversampling phases
`define ASCU_FRAME8 4'ha
`define ASCU_FRAME9 4'hb
`define ASCU_PH_S0 4'h7
`define ASCU_PH_S2 4'h9
`define ASCU_PH_LAST 4'hf

`endif

// [core/ascu_pkg.sv]
// types of the async serial character unit
// widths are written as literals; the package does not use the params header
package ascu_pkg;

  typedef enum logic [2:0] {
    TX_OFF,
    TX_PRE,
    TX_IDLE,
    TX_DATA,
    TX_BRK,
    TX_MARK
  } ascu_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } ascu_rx_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ascu_apb_req_t;

endpackage

// [core/ascu_top.sv]
// async serial character unit: transmitter with holding buffer, preamble and
// break, receiver with oversampling and holding buffer, APB register slave
// assumes baud tick enables from an outside rate generator, inputs synchronous
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ns
`include "ascu_params.svh"

module ascu_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // apb slave
  input wire ascu_pkg::ascu_apb_req_t apb_req_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // baud enables
  input wire logic tx_tick_i,
  input wire logic rx_tick16_i,
  // serial line
  input wire logic serial_rx_in_i,
  output logic tx_out_o,
  output logic tx_oe_o,
  // interrupt request
  output logic irq_o
);

  generate
    if (ADDR_W != 8)
    begin : g_bad_addr
      $error("ascu_top: ADDR_W must equal the request struct address width 8");
    end
  endgenerate

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire acc = apb_req_i.psel & apb_req_i.penable & pready_o;
  wire wr = acc & apb_req_i.pwrite;
  wire rd = acc & ~apb_req_i.pwrite;
  wire sel_data = apb_req_i.paddr == `ASCU_OFF_DATA;
  wire sel_stat = apb_req_i.paddr == `ASCU_OFF_STATUS;
  wire sel_c1 = apb_req_i.paddr == `ASCU_OFF_CTRL1;
  wire sel_c2 = apb_req_i.paddr == `ASCU_OFF_CTRL2;
  wire hit = sel_data | sel_stat | sel_c1 | sel_c2;
  wire data_wr = wr & sel_data;
  wire data_rd = rd & sel_data;
  wire stat_acc = acc & sel_stat;

  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic tx_arm;
  logic rx_arm;
  logic tx_buffer_empty_flag;
  logic tc;
  logic rxf;
  logic ovr;
  logic rx9;
  logic [7:0] rx_buf;

  wire wls = ctrl1[`ASCU_C1_WLS];
  wire tx9 = ctrl1[`ASCU_C1_TX9];
  wire te = ctrl2[`ASCU_C2_TE];
  wire re = ctrl2[`ASCU_C2_RE];
  wire send_break = ctrl2[`ASCU_C2_SBK];
  wire [3:0] len = wls ? `ASCU_FRAME9 : `ASCU_FRAME8;

  logic [7:0] stat_w;
  logic [7:0] c1_w;
  always_comb
  begin
    stat_w = 8'h00;
    stat_w[`ASCU_ST_TX_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag;
    stat_w[`ASCU_ST_TC] = tc;
    stat_w[`ASCU_ST_RXF] = rxf;
    stat_w[`ASCU_ST_OVR] = ovr;
    c1_w = ctrl1;
    c1_w[`ASCU_C1_RX9] = rx9;
  end

  // data reads see the holding buffer, never the shifter
  wire [7:0] rd_w = sel_data ? rx_buf :
                    sel_stat ? stat_w :
                    sel_c1 ? c1_w :
                    sel_c2 ? ctrl2 : 8'h00;

  // ----------------------------------------------------------------
  // apb slave: one wait state, errors on unmapped offsets
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      pready_o <= apb_req_i.psel & apb_req_i.penable & ~pready_o;
      pslverr_o <= apb_req_i.psel & apb_req_i.penable & ~pready_o & ~hit;
      prdata_o <= {24'h00_0000, rd_w};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctrl1 <= `ASCU_CTRL1_RST;
      ctrl2 <= `ASCU_CTRL2_RST;
    end
    else
    begin
      if (wr & sel_c1)
        ctrl1 <= apb_req_i.pwdata[7:0];
      if (wr & sel_c2)
        ctrl2 <= apb_req_i.pwdata[7:0];
    end
  end

  // a status access arms the clear; the following data access fires it
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tx_arm <= 1'b0;
      rx_arm <= 1'b0;
    end
    else
    begin
      if (stat_acc)
        tx_arm <= 1'b1;
      else if (data_wr)
        tx_arm <= 1'b0;
      if (stat_acc)
        rx_arm <= 1'b1;
      else if (data_rd)
        rx_arm <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  ascu_pkg::ascu_tx_state_t tx_state;
  logic [10:0] tx_sh;
  logic [3:0] tx_cnt;
  logic tx_go;
  logic [7:0] hold;
  logic hold_v;
  logic pre_pend;
  logic te_q;

  wire te_fall = te_q & ~te;
  wire te_rise = te & ~te_q;
  wire tx_busy = tx_state == ascu_pkg::TX_DATA || tx_state == ascu_pkg::TX_BRK
                 || tx_state == ascu_pkg::TX_MARK;
  wire tx_end = tx_busy & tx_tick_i & tx_go & (tx_cnt == 4'h1);
  wire idle_wr = data_wr & te & (tx_state == ascu_pkg::TX_IDLE) & ~send_break;
  // after a break, a cleared send_break asks for the closing mark bit
  wire want_mark = tx_state == ascu_pkg::TX_BRK & ~send_break;
  // a value left waiting while the preamble ran is taken up once idle
  wire idle_hold = te & (tx_state == ascu_pkg::TX_IDLE) & ~send_break & ~idle_wr & hold_v;
  wire load_hold = (tx_end & te & ~pre_pend & ~want_mark & ~send_break & hold_v) | idle_hold;
  wire [7:0] load_byte = idle_wr ? apb_req_i.pwdata[7:0] : hold;
  wire [10:0] frame_w = wls ? {1'b1, tx9, load_byte, 1'b0}
                            : {2'b11, load_byte, 1'b0};
  wire next_line = (tx_state == ascu_pkg::TX_DATA || tx_state == ascu_pkg::TX_BRK)
                   & tx_go ? tx_sh[0] : 1'b1;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tx_state <= ascu_pkg::TX_OFF;
      tx_sh <= 11'h7ff;
      tx_cnt <= 4'h0;
      tx_go <= 1'b0;
      pre_pend <= 1'b0;
      te_q <= 1'b0;
    end
    else
    begin
      te_q <= te;
      if (te_rise & tx_busy)
        pre_pend <= 1'b1;
      if (tx_tick_i & ~tx_go)
        tx_go <= 1'b1;
      case (tx_state)
        ascu_pkg::TX_OFF:
          if (te)
          begin
            tx_state <= ascu_pkg::TX_PRE;
            tx_cnt <= len;
            tx_go <= 1'b0;
          end
        ascu_pkg::TX_PRE:
          if (!te)
            tx_state <= ascu_pkg::TX_OFF;
          else if (tx_tick_i & tx_go)
          begin
            if (tx_cnt == 4'h1)
              tx_state <= ascu_pkg::TX_IDLE;
            tx_cnt <= tx_cnt - 4'h1;
          end
        ascu_pkg::TX_IDLE:
          if (!te)
            tx_state <= ascu_pkg::TX_OFF;
          else if (send_break | idle_wr | hold_v)
          begin
            tx_state <= send_break ? ascu_pkg::TX_BRK : ascu_pkg::TX_DATA;
            tx_sh <= send_break ? 11'h000 : frame_w;
            tx_cnt <= len;
            tx_go <= 1'b0;
          end
        default:
          if (tx_end)
          begin
            tx_go <= 1'b0;
            tx_cnt <= len;
            if (!te)
              tx_state <= ascu_pkg::TX_OFF;
            else if (want_mark)
            begin
              // chained bits keep the bit clock running so no gap appears
              tx_state <= ascu_pkg::TX_MARK;
              tx_cnt <= 4'h1;
              tx_go <= 1'b1;
            end
            else if (pre_pend)
            begin
              tx_state <= ascu_pkg::TX_PRE;
              pre_pend <= 1'b0;
            end
            else if (send_break)
            begin
              tx_state <= ascu_pkg::TX_BRK;
              tx_sh <= 11'h000;
              tx_go <= 1'b1;
            end
            else if (hold_v)
            begin
              tx_state <= ascu_pkg::TX_DATA;
              tx_sh <= frame_w;
              tx_go <= 1'b1;
            end
            else
              tx_state <= ascu_pkg::TX_IDLE;
          end
          else if (tx_busy & tx_tick_i & tx_go)
          begin
            tx_sh <= {1'b1, tx_sh[10:1]};
            tx_cnt <= tx_cnt - 4'h1;
          end
      endcase
    end
  end

  // holding buffer and transmit flags; a hardware set beats a clear
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      hold <= 8'h00;
      hold_v <= 1'b0;
      tx_buffer_empty_flag <= 1'b1;
      tc <= 1'b1;
    end
    else
    begin
      if (tx_arm & data_wr)
      begin
        tx_buffer_empty_flag <= 1'b0;
        tc <= 1'b0;
      end
      if (data_wr & ~idle_wr)
      begin
        hold <= apb_req_i.pwdata[7:0];
        hold_v <= 1'b1;
      end
      if (load_hold | te_fall)
        hold_v <= 1'b0;
      if (idle_wr | load_hold)
        tx_buffer_empty_flag <= 1'b1;
      if (tx_end & tx_state != ascu_pkg::TX_MARK)
        tc <= 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tx_out_o <= 1'b1;
      tx_oe_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      tx_out_o <= next_line;
      tx_oe_o <= tx_state != ascu_pkg::TX_OFF;
      irq_o <= (tx_buffer_empty_flag & ctrl2[`ASCU_C2_TIE]) | (tc & ctrl2[`ASCU_C2_TX_DONE_IRQ_EN]);
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  ascu_pkg::ascu_rx_state_t rx_state;
  logic [3:0] rx_ph;
  logic [2:0] rx_smp;
  logic [3:0] rx_bits;
  logic [8:0] rx_sh;
  logic rx_prev;

  // majority of three centre samples rejects single-sample glitches
  wire maj = (rx_smp[0] & rx_smp[1]) | (rx_smp[0] & rx_smp[2])
             | (rx_smp[1] & rx_smp[2]);
  wire ph_end = rx_tick16_i & (rx_ph == `ASCU_PH_LAST);
  wire rx_done = ph_end & (rx_state == ascu_pkg::RX_STOP);
  wire [3:0] nbits = wls ? 4'h9 : 4'h8;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rx_state <= ascu_pkg::RX_IDLE;
      rx_ph <= 4'h0;
      rx_smp <= 3'h7;
      rx_bits <= 4'h0;
      rx_sh <= 9'h000;
      rx_prev <= 1'b1;
    end
    else if (rx_tick16_i)
    begin
      rx_prev <= serial_rx_in_i;
      rx_ph <= rx_ph + 4'h1;
      if (rx_ph >= `ASCU_PH_S0 && rx_ph <= `ASCU_PH_S2)
        rx_smp <= {rx_smp[1:0], serial_rx_in_i};
      case (rx_state)
        ascu_pkg::RX_IDLE:
          if (re & rx_prev & ~serial_rx_in_i)
          begin
            rx_state <= ascu_pkg::RX_START;
            rx_ph <= 4'h1;
          end
        ascu_pkg::RX_START:
          if (ph_end)
          begin
            rx_state <= maj ? ascu_pkg::RX_IDLE : ascu_pkg::RX_DATA;
            rx_bits <= 4'h0;
          end
        ascu_pkg::RX_DATA:
          if (ph_end)
          begin
            rx_sh <= {maj, rx_sh[8:1]};
            rx_bits <= rx_bits + 4'h1;
            if (rx_bits == nbits - 4'h1)
              rx_state <= ascu_pkg::RX_STOP;
          end
        default:
          if (ph_end)
            rx_state <= ascu_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rx_buf <= 8'h00;
      rx9 <= 1'b0;
      rxf <= 1'b0;
      ovr <= 1'b0;
    end
    else
    begin
      if (rx_arm & data_rd)
      begin
        rxf <= 1'b0;
        ovr <= 1'b0;
      end
      if (rx_done & rxf)
        ovr <= 1'b1;
      else if (rx_done)
      begin
        rx_buf <= wls ? rx_sh[7:0] : rx_sh[8:1];
        rx9 <= rx_sh[8];
        rxf <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_pin_release: assert property (tx_state == ascu_pkg::TX_OFF |=> !tx_oe_o)
    else $error("output enabled while transmitter off");
  a_idle_high: assert property (tx_state == ascu_pkg::TX_IDLE |=> tx_out_o)
    else $error("line not high while idle");
  a_start_low: assert property ((tx_state == ascu_pkg::TX_DATA && tx_tick_i && !tx_go)
    |=> ##1 !tx_out_o)
    else $error("start bit not low");
  a_pre_len: assert property ((tx_state == ascu_pkg::TX_OFF && te)
    |=> tx_state == ascu_pkg::TX_PRE && tx_cnt == $past(len))
    else $error("preamble not started with frame length");
  a_tx_buffer_empty_flag_clear: assert property ($fell(tx_buffer_empty_flag) |-> $past(tx_arm && data_wr))
    else $error("empty flag cleared without sequence");
  a_tc_clear: assert property ($fell(tc) |-> $past(tx_arm && data_wr))
    else $error("done flag cleared without sequence");
  a_direct_load: assert property (idle_wr
    |=> tx_state == ascu_pkg::TX_DATA && tx_buffer_empty_flag && !tx_sh[0])
    else $error("idle write did not start a frame");
  a_irq_level: assert property ((tx_buffer_empty_flag && ctrl2[`ASCU_C2_TIE])
    |=> irq_o || !$past(tx_buffer_empty_flag))
    else $error("interrupt missing for empty flag");
  a_rx_full: assert property ((rx_done && !rxf) |=> rxf)
    else $error("full flag not set on completed character");
  a_rx_overrun: assert property ((rx_done && rxf) |=> ovr && $stable(rx_buf))
    else $error("overrun lost flag or buffer");

endmodule

// [dv/ascu_remote_node.sv]
// remote serial node model: drives the receive line of the unit
// assumes a sixteen-per-bit receive tick from the bench's rate generator
`timescale 1ns/1ns
module ascu_remote_node (
  // clock and tick
  input wire logic clk_i,
  input wire logic tick16_i,
  // serial line
  output logic line_o
);
  // line rests high between frames, so idle needs no driving
  initial line_o = 1'b1;
  // level held for n receive ticks
  task automatic hold(input logic v, input int n);
    line_o <= v;
    repeat (n)
    begin
      @(posedge clk_i);
      while (tick16_i !== 1'b1) @(posedge clk_i);
    end
  endtask
  // start, data lsb first, stop; sixteen ticks per bit
  task automatic send(input logic [8:0] d, input int nbits);
    hold(1'b1, 1);
    hold(1'b0, 16);
    for (int i = 0; i < nbits; i++)
      hold(d[i], 16);
    hold(1'b1, 16);
  endtask
  // low pulse of a quarter bit, too short to pass as a start bit
  task automatic glitch();
    hold(1'b1, 1);
    hold(1'b0, 4);
    hold(1'b1, 16);
  endtask
endmodule

// [dv/test_async_serial_char_unit.sv]
// self-checking bench of the async serial character unit
// assumes the unit's params header and package; bench makes clock and ticks
`timescale 1ns/1ns
`include "ascu_params.svh"
module test_async_serial_char_unit;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ascu_pkg::ascu_apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, tx_out, tx_oe, irq, rx_line, last_err;
  logic tx_tick = 1'b0;
  logic rx_tick16 = 1'b0;
  logic [5:0] tick_cnt = 6'h00;
  logic [31:0] rd;
  int mismatches = 0;
  int checked = 0;

  initial forever #5 clk = ~clk;
  // one bit time is 64 clocks: one transmit tick, sixteen receive ticks
  always @(posedge clk)
  begin
    tick_cnt <= tick_cnt + 6'h01;
    tx_tick <= (tick_cnt == 6'h3f);
    rx_tick16 <= (tick_cnt[1:0] == 2'h3);
  end

  ascu_top #(.ADDR_W(8)) ascu_top_i (.clk_i(clk), .reset_i(rst), .apb_req_i(req),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .tx_tick_i(tx_tick),
    .rx_tick16_i(rx_tick16), .serial_rx_in_i(rx_line), .tx_out_o(tx_out),
    .tx_oe_o(tx_oe), .irq_o(irq));
  ascu_remote_node ascu_remote_node_i (.clk_i(clk), .tick16_i(rx_tick16), .line_o(rx_line));

  // ----
  // shared tasks
  // ----
  task automatic report_and_stop();
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang(input string what);
    mismatches++;
    $display("FAIL %s expected event seen timeout", what);
    report_and_stop();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, wd};
    @(posedge clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 20) hang("pready");
    end
    while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // n counts the clocks of high line before the start bit
  task automatic frame(input int nb, input logic [11:0] exp, input string what,
                       output int n);
    n = 0;
    while (tx_out !== 1'b0)
    begin
      @(posedge clk);
      n++;
      if (n > 2000) hang("start bit");
    end
    cyc(32);
    for (int i = 0; i < nb; i++)
    begin
      chk(what, 32'(exp[i]), 32'(tx_out));
      if (i < nb - 1) cyc(64);
    end
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset();
    chk("oe at reset", 32'h0, 32'(tx_oe));
    rdc(`ASCU_OFF_STATUS, 32'hc0, "status reset");
    rdc(`ASCU_OFF_CTRL1, 32'h0, "ctrl1 reset");
    rdc(`ASCU_OFF_CTRL2, 32'h0, "ctrl2 reset");
    rdc(8'h10, 32'h0, "unmapped read");
    chk("unmapped err", 32'h1, 32'(last_err));
  endtask
  task automatic t_tx_first();
    int n;
    wr(`ASCU_OFF_CTRL2, 32'h0c);
    rdc(`ASCU_OFF_STATUS, 32'hc0, "status idle");
    wr(`ASCU_OFF_DATA, 32'ha5);
    frame(10, {2'b00, 1'b1, 8'ha5, 1'b0}, "first frame", n);
    chk("preamble length", 32'h1, 32'(n >= 640 && n <= 740));
    chk("oe enabled", 32'h1, 32'(tx_oe));
    cyc(64);
    rdc(`ASCU_OFF_STATUS, 32'hc0, "done after stop");
  endtask
  task automatic t_b2b();
    int n;
    rdc(`ASCU_OFF_STATUS, 32'hc0, "status arm");
    wr(`ASCU_OFF_DATA, 32'h01);
    rdc(`ASCU_OFF_STATUS, 32'h80, "empty at once");
    wr(`ASCU_OFF_DATA, 32'h80);
    rdc(`ASCU_OFF_STATUS, 32'h00, "buffer held");
    frame(10, {2'b00, 1'b1, 8'h01, 1'b0}, "frame one", n);
    frame(10, {2'b00, 1'b1, 8'h80, 1'b0}, "frame two", n);
    chk("no gap", 32'h1, 32'(n <= 40));
    cyc(64);
    rdc(`ASCU_OFF_STATUS, 32'hc0, "both sent");
  endtask
  task automatic t_nine();
    int n;
    wr(`ASCU_OFF_CTRL1, 32'h50);
    rdc(`ASCU_OFF_STATUS, 32'hc0, "status arm");
    wr(`ASCU_OFF_DATA, 32'h3c);
    frame(11, {1'b0, 1'b1, 1'b1, 8'h3c, 1'b0}, "nine bit frame", n);
    ascu_remote_node_i.send(9'h1a5, 9);
    cyc(16);
    rdc(`ASCU_OFF_STATUS, 32'he0, "rx full nine");
    rdc(`ASCU_OFF_CTRL1, 32'hd0, "ninth received");
    rdc(`ASCU_OFF_DATA, 32'ha5, "rx nine data");
    wr(`ASCU_OFF_CTRL1, 32'h00);
  endtask
  task automatic t_rx();
    ascu_remote_node_i.send(9'h05a, 8);
    cyc(16);
    rdc(`ASCU_OFF_STATUS, 32'he0, "rx full");
    rdc(`ASCU_OFF_DATA, 32'h5a, "rx data");
    rdc(`ASCU_OFF_STATUS, 32'hc0, "rx full cleared");
    ascu_remote_node_i.send(9'h011, 8);
    ascu_remote_node_i.send(9'h022, 8);
    cyc(16);
    rdc(`ASCU_OFF_STATUS, 32'he8, "overrun");
    rdc(`ASCU_OFF_DATA, 32'h11, "buffer kept");
    rdc(`ASCU_OFF_STATUS, 32'hc0, "overrun cleared");
    ascu_remote_node_i.glitch();
    cyc(300);
    rdc(`ASCU_OFF_STATUS, 32'hc0, "glitch ignored");
  endtask
  task automatic t_break();
    int n;
    wr(`ASCU_OFF_CTRL2, 32'h0d);
    n = 0;
    while (tx_out !== 1'b0)
    begin
      @(posedge clk);
      n++;
      if (n > 200) hang("break start");
    end
    cyc(32);
    // cleared mid second break: it completes, then one high bit
    for (int i = 0; i < 21; i++)
    begin
      chk("break bit", 32'(i == 20), 32'(tx_out));
      if (i == 14)
      begin
        wr(`ASCU_OFF_CTRL2, 32'h0c);
        cyc(60);
      end
      else
        cyc(64);
    end
  endtask
  task automatic t_irq();
    int n;
    wr(`ASCU_OFF_CTRL2, 32'h8c);
    cyc(3);
    chk("irq empty", 32'h1, 32'(irq));
    wr(`ASCU_OFF_CTRL2, 32'h4c);
    rdc(`ASCU_OFF_STATUS, 32'hc0, "status arm");
    wr(`ASCU_OFF_DATA, 32'hff);
    cyc(3);
    chk("irq done cleared", 32'h0, 32'(irq));
    frame(10, {2'b00, 1'b1, 8'hff, 1'b0}, "irq frame", n);
    cyc(64);
    chk("irq done", 32'h1, 32'(irq));
  endtask
  task automatic t_off();
    int n;
    wr(`ASCU_OFF_CTRL2, 32'h04);
    n = 0;
    while (tx_oe !== 1'b0)
    begin
      @(posedge clk);
      n++;
      if (n > 200) hang("pin release");
    end
    chk("pin released", 32'h0, 32'(tx_oe));
    chk("irq off", 32'h0, 32'(irq));
  endtask

  // ----
  // main sequence
  // ----
  initial
  begin
    last_err = 1'b0;
    cyc(10);
    rst <= 1'b0;
    t_reset();
    t_tx_first();
    t_b2b();
    t_nine();
    t_rx();
    t_break();
    t_irq();
    t_off();
    report_and_stop();
  end
endmodule
